// ===== logic/wdg_map.vh
// Purpose: Register map, field positions and counter constants for the watchdog block
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes:   Definitions only
`ifndef WDG_MAP_VH
`define WDG_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define WDG_OFS_RSTCTL    8'h00
`define WDG_OFS_WDCFG     8'h04
`define WDG_OFS_DSCFG     8'h08
`define WDG_OFS_IRQSTAT   8'h0C
`define WDG_OFS_IRQMASK   8'h10
`define WDG_OFS_STATUS    8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define WDG_RC_SWEN       5
`define WDG_RC_FLAG       4
`define WDG_CF_HWEN1      7
`define WDG_CF_WINOFF     6
`define WDG_CF_HWEN0      5
`define WDG_CF_PRESEL     4
`define WDG_DS_EN         7
`define WDG_DS_CLKSEL     4
`define WDG_EV_TIMEOUT    0
`define WDG_EV_EARLY      1
`define WDG_EV_DSTIMEOUT  2
`define WDG_EV_WAKE       3

// ----------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------
`define WDG_RST_WDCFG     8'hFF
`define WDG_RST_DSCFG     8'h9F
`define WDG_HW_ALWAYS     2'h3
`define WDG_HW_SOFT       2'h2
`define WDG_HW_ACTIVE     2'h1
`define WDG_RESP_OKAY     2'h0
`define WDG_RESP_SLVERR   2'h2

// ----------------------------------------------------------------------
// Counter constants
// ----------------------------------------------------------------------
`define WDG_PRE_LONG      23'h000080
`define WDG_PRE_SHORT     23'h000020
`define WDG_DS_BASE_LOG2  6'h06
`define WDG_DS_STEP_LOG2  6'h02

`endif

// ===== logic/wdg_ds_counter.v
// Purpose: Deep sleep watchdog counter with power-of-two postscaler
// Assumes: Tick input is a one-cycle enable from the chosen low-power source
// Notes:   Period is 2^(base + step * postscale) ticks
`default_nettype none
`include "wdg_map.vh"

module wdg_ds_counter #(
    parameter CNT_W = 37
) (
    // Clock and reset
    input  wire        clk_sys_i,
    input  wire        rst_i,
    input  wire        ce_i,
    // Control
    input  wire        run_i,
    input  wire        tick_i,
    input  wire [3:0]  postscale_i,
    // Event
    output reg         timeout_o
);

    reg  [CNT_W-1:0] count;
    wire [5:0]       log2_period;
    wire [CNT_W-1:0] last_count;

    // Period steps by a factor of four per postscale code
    assign log2_period = `WDG_DS_BASE_LOG2 + {postscale_i, 1'b0};
    assign last_count  = ({{(CNT_W-1){1'b0}}, 1'b1} << log2_period) - 1'b1;

    // Counting only while enabled and asleep; cleared otherwise
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            count     <= {CNT_W{1'b0}};
            timeout_o <= 1'b0;
        end else if (ce_i) begin
            timeout_o <= 1'b0;
            if (!run_i) begin
                count <= {CNT_W{1'b0}};
            end else if (tick_i) begin
                if (count >= last_count) begin
                    count     <= {CNT_W{1'b0}};
                    timeout_o <= 1'b1; // R14
                end else begin
                    count <= count + 1'b1; // R10
                end
            end
        end
    end

endmodule // wdg_ds_counter
`default_nettype wire

// ===== logic/wdg_top.v
// Purpose: Windowed main watchdog and deep sleep watchdog with AXI4-Lite registers
// Assumes: All inputs synchronous to clk_sys_i; oscillator ticks are one-cycle enables
// Notes:   Reset request and wake outputs are one-cycle pulses
//
// Overview of operation
// R1 - Windowed mode: clear restarts counter only in last quarter of period; the code also zeroes the count on an early clear
// R2 - Windowed mode: clear before window opens raises watchdog reset
// R3 - Window-disable bit zero selects windowed mode, one selects standard
// R4 - Hardware enable field 11 keeps watchdog always on
// R5 - Hardware enable field 10 hands running state to software enable bit
// R6 - Software enable bit five set starts, cleared stops watchdog
// R7 - Any device reset clears software enable bit
// R8 - Field 01 runs watchdog in Run and Idle, stops it in Sleep
// R9 - With field 01, writes to software enable bit have no effect
// R10 - Deep sleep watchdog keeps counting in Deep Sleep when enabled
// R11 - Deep sleep clock is secondary or low-power RC, chosen by bit 4
// R12 - Four-bit postscale picks deep sleep time-out, 2.1 ms to 25.7 days
// R13 - Enabling deep sleep watchdog forces its clock source on
// R14 - Deep sleep time-out wakes device from Deep Sleep
// R15 - Field 11 time-out in Sleep or Idle wakes device instead
// R16 - Time-out flag bit 4 set by hardware, cleared only by software; the code also clears it on rst_i
// R17 - Clear or power-save instruction zeroes prescaler and postscaler counts
// R18 - Running time-out or early clear requests reset and sets flag
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`default_nettype none
`include "wdg_map.vh"

module wdg_top #(
    parameter ADDR_W = 8,
    parameter CNT_W  = 23
) (
    // Clock, reset, enable
    input  wire              clk_sys_i,
    input  wire              rst_i,
    input  wire              ce_i,
    // AXI4-Lite write address
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    // AXI4-Lite read address
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // Processor events and power state
    input  wire              wd_clear_i,
    input  wire              pwr_save_i,
    input  wire              sleep_i,
    input  wire              idle_i,
    input  wire              deep_sleep_i,
    // Oscillator ticks
    input  wire              rc_tick_i,
    input  wire              sec_tick_i,
    // Results
    output reg               wdt_reset_req_o,
    output reg               wake_o,
    output wire              ds_wake_o,
    output wire              sec_force_on_o,
    output wire              rc_force_on_o,
    output wire              wdt_running_o,
    output wire              irq_o
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    reg              sw_en;
    reg              wdt_flag;
    reg  [7:0]       wd_cfg;
    reg  [7:0]       ds_cfg;
    reg  [3:0]       irq_stat;
    reg  [3:0]       irq_mask;
    reg              aw_hold;
    reg              w_hold;
    reg  [ADDR_W-1:0] aw_addr;
    reg  [31:0]      w_data;
    reg  [3:0]       w_strb;
    reg  [CNT_W-1:0] count;

    // ------------------------------------------------------------------
    // Main watchdog enable policy
    // ------------------------------------------------------------------
    wire [1:0] hw_en;
    wire       window_dis;
    wire       wdt_en;
    wire       wdt_run;

    assign hw_en      = {wd_cfg[`WDG_CF_HWEN1], wd_cfg[`WDG_CF_HWEN0]};
    assign window_dis = wd_cfg[`WDG_CF_WINOFF];

    // Sleep only stops the counter for the run-and-idle policy
    assign wdt_en = (hw_en == `WDG_HW_ALWAYS) |                // R4
                    ((hw_en == `WDG_HW_SOFT) & sw_en) |         // R5
                    ((hw_en == `WDG_HW_ACTIVE) & ~sleep_i);     // R8
    // Deep Sleep powers the main watchdog down in every policy
    assign wdt_run       = wdt_en & ~deep_sleep_i;
    assign wdt_running_o = wdt_run;

    // ------------------------------------------------------------------
    // Period and window arithmetic
    // ------------------------------------------------------------------
    wire [CNT_W-1:0] pre_ratio;
    wire [CNT_W-1:0] period;
    wire [CNT_W-1:0] window_start;
    wire             window_open;
    wire             at_terminal;

    // Prescale and postscale folded into one counter
    assign pre_ratio    = wd_cfg[`WDG_CF_PRESEL] ? `WDG_PRE_LONG : `WDG_PRE_SHORT;
    assign period       = pre_ratio << wd_cfg[3:0];
    assign window_start = period - (period >> 2);
    assign window_open  = (count >= window_start);                  // R1
    assign at_terminal  = (count == period - 1'b1);

    // ------------------------------------------------------------------
    // Main watchdog events
    // ------------------------------------------------------------------
    wire clear_req;
    wire early_clear;
    wire timeout_evt;
    wire asleep;

    assign asleep      = sleep_i | idle_i;
    assign clear_req   = ce_i & wd_clear_i & wdt_run;
    // Early clears only matter when the window is armed
    assign early_clear = clear_req & ~window_dis & ~window_open;     // R2 R3
    assign timeout_evt = ce_i & wdt_run & rc_tick_i & at_terminal;

    // Counter: clear and power-save restart it, no tick is lost otherwise
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            count <= {CNT_W{1'b0}};
        end else if (ce_i) begin
            if (!wdt_run) begin
                count <= {CNT_W{1'b0}};
            end else if (wd_clear_i | pwr_save_i) begin
                count <= {CNT_W{1'b0}}; // R17 R1
            end else if (rc_tick_i) begin
                if (at_terminal) begin
                    count <= {CNT_W{1'b0}};
                end else begin
                    count <= count + 1'b1;
                end
            end
        end
    end

    // Reset request versus wake: a sleeping core is woken, not reset
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            wdt_reset_req_o <= 1'b0;
            wake_o          <= 1'b0;
        end else if (ce_i) begin
            wdt_reset_req_o <= early_clear | (timeout_evt & ~asleep); // R18 R2
            wake_o          <= timeout_evt & asleep;                  // R15
        end
    end

    // ------------------------------------------------------------------
    // Deep sleep watchdog
    // ------------------------------------------------------------------
    wire ds_en;
    wire ds_use_rc;
    wire ds_tick;

    assign ds_en     = ds_cfg[`WDG_DS_EN];
    assign ds_use_rc = ds_cfg[`WDG_DS_CLKSEL];
    assign ds_tick   = ds_use_rc ? rc_tick_i : sec_tick_i;  // R11
    // Source forced on so the counter never starves
    assign rc_force_on_o  = ds_en & ds_use_rc;               // R13
    assign sec_force_on_o = ds_en & ~ds_use_rc;              // R13

    wdg_ds_counter #(
        .CNT_W (37)
    ) u_ds_counter (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .run_i       (ds_en & deep_sleep_i),
        .tick_i      (ds_tick),
        .postscale_i (ds_cfg[3:0]),       // R12
        .timeout_o   (ds_wake_o)
    );

    // ------------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------------
    wire [3:0] ev_set;

    assign ev_set[`WDG_EV_TIMEOUT]   = timeout_evt;
    assign ev_set[`WDG_EV_EARLY]     = early_clear;
    assign ev_set[`WDG_EV_DSTIMEOUT] = ds_wake_o & ce_i;
    assign ev_set[`WDG_EV_WAKE]      = timeout_evt & asleep;
    assign irq_o = |(irq_stat & irq_mask);

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    wire do_write;
    wire wr_rstctl;
    wire wr_wdcfg;
    wire wr_dscfg;
    wire wr_stat;
    wire wr_mask;
    wire wr_hit;

    // Address and data taken in either order, one write in flight
    assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
    assign do_write      = ce_i & aw_hold & w_hold;
    assign wr_rstctl = do_write & w_strb[0] & (aw_addr == `WDG_OFS_RSTCTL);
    assign wr_wdcfg  = do_write & w_strb[0] & (aw_addr == `WDG_OFS_WDCFG);
    assign wr_dscfg  = do_write & w_strb[0] & (aw_addr == `WDG_OFS_DSCFG);
    assign wr_stat   = do_write & w_strb[0] & (aw_addr == `WDG_OFS_IRQSTAT);
    assign wr_mask   = do_write & w_strb[0] & (aw_addr == `WDG_OFS_IRQMASK);
    assign wr_hit    = (aw_addr == `WDG_OFS_RSTCTL) | (aw_addr == `WDG_OFS_WDCFG) |
                       (aw_addr == `WDG_OFS_DSCFG) | (aw_addr == `WDG_OFS_IRQSTAT) |
                       (aw_addr == `WDG_OFS_IRQMASK) | (aw_addr == `WDG_OFS_STATUS);

    // Handshake and response
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            aw_hold      <= 1'b0;
            w_hold       <= 1'b0;
            aw_addr      <= {ADDR_W{1'b0}};
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `WDG_RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_hold      <= 1'b0;
                w_hold       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `WDG_RESP_OKAY : `WDG_RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control registers; device reset drops the software enable
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            sw_en    <= 1'b0; // R7
            wd_cfg   <= `WDG_RST_WDCFG;
            ds_cfg   <= `WDG_RST_DSCFG;
            irq_mask <= 4'h0;
        end else if (ce_i) begin
            // Only the software policy listens to the enable bit
            if (wr_rstctl & (hw_en == `WDG_HW_SOFT)) begin
                sw_en <= w_data[`WDG_RC_SWEN]; // R6 R9
            end
            if (wr_wdcfg) begin
                wd_cfg <= w_data[7:0];
            end
            if (wr_dscfg) begin
                ds_cfg <= w_data[7:0];
            end
            if (wr_mask) begin
                irq_mask <= w_data[3:0];
            end
        end
    end

    // Sticky flags: hardware set wins over a same-cycle software clear
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            wdt_flag <= 1'b0;
            irq_stat <= 4'h0;
        end else if (ce_i) begin
            if (early_clear | timeout_evt) begin
                wdt_flag <= 1'b1; // R16 R18
            end else if (wr_rstctl & ~w_data[`WDG_RC_FLAG]) begin
                wdt_flag <= 1'b0; // R16
            end
            irq_stat <= (irq_stat & ~(wr_stat ? w_data[3:0] : 4'h0)) | ev_set;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    reg [31:0] rd_mux;
    reg        rd_hit;

    assign s_axi_arready = ~s_axi_rvalid;

    // Read decode; undefined bits read as zero
    always @* begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `WDG_OFS_RSTCTL: begin
                rd_mux[`WDG_RC_SWEN] = sw_en;
                rd_mux[`WDG_RC_FLAG] = wdt_flag;
            end
            `WDG_OFS_WDCFG: begin
                rd_mux[7:0] = wd_cfg;
            end
            `WDG_OFS_DSCFG: begin
                rd_mux[7:0] = ds_cfg;
            end
            `WDG_OFS_IRQSTAT: begin
                rd_mux[3:0] = irq_stat;
            end
            `WDG_OFS_IRQMASK: begin
                rd_mux[3:0] = irq_mask;
            end
            `WDG_OFS_STATUS: begin
                rd_mux[0]      = wdt_run;
                rd_mux[1]      = window_open;
                rd_mux[CNT_W+7:8] = count;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read data registered; one read in flight
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `WDG_RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_hit ? `WDG_RESP_OKAY : `WDG_RESP_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // wdg_top
`default_nettype wire

// ===== dv/wdg_top_checker.sv
// Purpose: Port-level assertions for the watchdog top
// Assumes: One clock domain, synchronous active-high reset
// Notes:   Bound to the design from the bench top file
`default_nettype none

module wdg_top_checker (
    // Clock and reset
    input wire logic        clk_sys_i,
    input wire logic        rst_i,
    // Register bus handshakes
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Power state and results
    input wire logic        sleep_i,
    input wire logic        idle_i,
    input wire logic        deep_sleep_i,
    input wire logic        wdt_reset_req_o,
    input wire logic        wake_o,
    input wire logic        ds_wake_o,
    input wire logic        sec_force_on_o,
    input wire logic        rc_force_on_o,
    input wire logic        wdt_running_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    // Reset masks every check, so nothing fires while registers reload
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    a_cfg_after_reset: assert property ($past(rst_i) && !deep_sleep_i |->
        wdt_running_o && rc_force_on_o && !sec_force_on_o)
        else $error("watchdog or clock source off after reset");
    a_wake_in_sleep: assert property (wake_o |-> $past(sleep_i || idle_i) && !wdt_reset_req_o)
        else $error("wake pulse outside sleep or idle");
    a_reset_awake: assert property (wdt_reset_req_o |-> !$past(sleep_i))
        else $error("reset request while asleep");
    a_ds_wake_deep: assert property (ds_wake_o |-> $past(deep_sleep_i))
        else $error("deep sleep wake outside deep sleep");
    a_ds_wake_pulse: assert property (ds_wake_o |=> !ds_wake_o)
        else $error("deep sleep wake longer than one cycle");
    a_one_source: assert property (!(sec_force_on_o && rc_force_on_o))
        else $error("both deep sleep clock sources forced");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_readies_gated: assert property ((s_axi_arready != s_axi_rvalid) &&
        !(s_axi_bvalid && (s_axi_awready || s_axi_wready)))
        else $error("bus ready while response pending");
endmodule // wdg_top_checker

`default_nettype wire

// ===== dv/wdg_top_test.sv
// Purpose: Self-checking bench for the watchdog top
// Assumes: Short main period: prescale 1:32, postscale code 0
// Notes:   Oscillator ticks come every other clock
`default_nettype none
`include "wdg_map.vh"

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("BAD t=%0t got %0h exp %0h", $time, g, e); end end

module wdg_top_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------------
    logic        clk_sys_i, rst_i, ce_i;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic        wd_clear_i, pwr_save_i, sleep_i, idle_i, deep_sleep_i;
    logic        rc_tick_i, sec_tick_i, wdt_reset_req_o, wake_o, ds_wake_o;
    logic        sec_force_on_o, rc_force_on_o, wdt_running_o, irq_o;
    int          err_total, samples_checked, n_rst, n_wake, n_ds;

    wdg_top u_dut (.*);

    // Clock, 25 ns period
    initial begin
        clk_sys_i = 1'h0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    // Pulse counters; non-blocking so tasks read them race-free
    always @(posedge clk_sys_i) begin
        if (wdt_reset_req_o === 1'h1) n_rst <= n_rst + 1;
        if (wake_o === 1'h1) n_wake <= n_wake + 1;
        if (ds_wake_o === 1'h1) n_ds <= n_ds + 1;
    end

    // ------------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // Write; valids dropped as each channel is taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er = `WDG_RESP_OKAY);
        int n;
        n = 0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        do begin
            @(posedge clk_sys_i);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1 && n < 40);
        s_axi_bready <= 1'h0;
        `CHK(s_axi_bresp, er)
        if (n >= 40) begin err_total++; finish_test(); end
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er = `WDG_RESP_OKAY);
        int n;
        n = 0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do begin
            @(posedge clk_sys_i);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1 && n < 40);
        s_axi_rready <= 1'h0;
        `CHK(s_axi_rdata, e)
        `CHK(s_axi_rresp, er)
        if (n >= 40) begin err_total++; finish_test(); end
    endtask

    // Ticks of one source; two spare edges let pulses be counted
    task automatic ticks(input int n, input logic s);
        repeat (n) begin
            sec_tick_i <= s;
            rc_tick_i  <= !s;
            @(posedge clk_sys_i);
            sec_tick_i <= 1'h0;
            rc_tick_i  <= 1'h0;
            @(posedge clk_sys_i);
        end
        step(2);
    endtask

    task automatic instr(input logic sav);
        wd_clear_i <= !sav;
        pwr_save_i <= sav;
        @(posedge clk_sys_i);
        wd_clear_i <= 1'h0;
        pwr_save_i <= 1'h0;
        step(2);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_vals();
        axr(`WDG_OFS_RSTCTL, 32'h0);
        axr(`WDG_OFS_WDCFG, 32'hFF);
        axr(`WDG_OFS_DSCFG, 32'h9F);
        `CHK(wdt_running_o, 1'h1)
        axr(8'h18, 32'h0, `WDG_RESP_SLVERR);
        axw(8'h18, 32'hFF, `WDG_RESP_SLVERR);
        $display("reset values done");
    endtask

    // Both instructions restart the count; the 32nd tick then times out
    task automatic t_timeout();
        axw(`WDG_OFS_WDCFG, 32'hE0);
        instr(1'h1);
        ticks(20, 1'h0);
        instr(1'h0);
        ticks(20, 1'h0);
        instr(1'h1);
        ticks(31, 1'h0);
        `CHK(n_rst, 0)
        ticks(1, 1'h0);
        `CHK(n_rst, 1)
        axw(`WDG_OFS_RSTCTL, 32'h10);
        axr(`WDG_OFS_RSTCTL, 32'h10);
        `CHK(irq_o, 1'h0)
        axw(`WDG_OFS_IRQMASK, 32'h1);
        `CHK(irq_o, 1'h1)
        axw(`WDG_OFS_IRQSTAT, 32'h1);
        `CHK(irq_o, 1'h0)
        axw(`WDG_OFS_RSTCTL, 32'h0);
        axr(`WDG_OFS_RSTCTL, 32'h0);
        $display("timeout done");
    endtask

    // Window opens at count 24 of 32
    task automatic t_window();
        axw(`WDG_OFS_WDCFG, 32'hA0);
        instr(1'h1);
        ticks(23, 1'h0);
        axr(`WDG_OFS_STATUS, 32'h1701);
        instr(1'h0);
        `CHK(n_rst, 2)
        axr(`WDG_OFS_IRQSTAT, 32'h2);
        ticks(24, 1'h0);
        axr(`WDG_OFS_STATUS, 32'h1803);
        instr(1'h0);
        ticks(31, 1'h0);
        `CHK(n_rst, 2)
        ticks(1, 1'h0);
        `CHK(n_rst, 3)
        axw(`WDG_OFS_IRQSTAT, 32'hF);
        axw(`WDG_OFS_RSTCTL, 32'h0);
        $display("window done");
    endtask

    task automatic t_soft();
        axw(`WDG_OFS_WDCFG, 32'h40);
        `CHK(wdt_running_o, 1'h0)
        axw(`WDG_OFS_WDCFG, 32'hC0);
        `CHK(wdt_running_o, 1'h0)
        axw(`WDG_OFS_RSTCTL, 32'h20);
        `CHK(wdt_running_o, 1'h1)
        axw(`WDG_OFS_RSTCTL, 32'h0);
        `CHK(wdt_running_o, 1'h0)
        axw(`WDG_OFS_RSTCTL, 32'h20);
        rst_i <= 1'h1;
        step(2);
        rst_i <= 1'h0;
        step(1);
        axr(`WDG_OFS_RSTCTL, 32'h0);
        axw(`WDG_OFS_WDCFG, 32'h60);
        axw(`WDG_OFS_RSTCTL, 32'h20);
        axr(`WDG_OFS_RSTCTL, 32'h0);
        axw(`WDG_OFS_RSTCTL, 32'h0);
        `CHK(wdt_running_o, 1'h1)
        sleep_i <= 1'h1;
        step(1);
        `CHK(wdt_running_o, 1'h0)
        sleep_i <= 1'h0;
        idle_i  <= 1'h1;
        step(1);
        `CHK(wdt_running_o, 1'h1)
        idle_i <= 1'h0;
        $display("software enable done");
    endtask

    task automatic t_sleep();
        axw(`WDG_OFS_WDCFG, 32'hE0);
        instr(1'h1);
        sleep_i <= 1'h1;
        step(1);
        `CHK(wdt_running_o, 1'h1)
        ticks(32, 1'h0);
        sleep_i <= 1'h0;
        `CHK(n_wake, 1)
        `CHK(n_rst, 3)
        $display("sleep wake done");
    endtask

    // Code 0 gives 64 ticks of the chosen source
    task automatic t_deep();
        axw(`WDG_OFS_DSCFG, 32'h80);
        `CHK(sec_force_on_o, 1'h1)
        `CHK(rc_force_on_o, 1'h0)
        deep_sleep_i <= 1'h1;
        step(1);
        ticks(63, 1'h1);
        `CHK(n_ds, 0)
        ticks(1, 1'h1);
        `CHK(n_ds, 1)
        ticks(64, 1'h0);
        `CHK(n_ds, 1)
        `CHK(n_rst, 3)
        deep_sleep_i <= 1'h0;
        axw(`WDG_OFS_DSCFG, 32'h10);
        `CHK(rc_force_on_o, 1'h0)
        $display("deep sleep done");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst_i, ce_i, s_axi_wstrb} = 6'h3F;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {wd_clear_i, pwr_save_i, sleep_i, idle_i, deep_sleep_i, rc_tick_i, sec_tick_i} = '0;
        step(8);
        rst_i <= 1'h0;
        step(1);
        t_reset_vals();
        t_timeout();
        t_window();
        t_soft();
        t_sleep();
        t_deep();
        finish_test();
    end
endmodule // wdg_top_test

bind wdg_top wdg_top_checker u_chk (.*);

`default_nettype wire
